// *** common/xars_params.svh ***
// Constants for the architectural register state block: bus offsets, field positions, resets.
// Assumes inclusion by bare name from the register block design file.
`ifndef XARS_PARAMS_SVH
`define XARS_PARAMS_SVH
// Register word offsets on the bus (byte addresses).
`define XARS_OFF_FLAGS 8'h00
`define XARS_OFF_IPTR 8'h04
`define XARS_OFF_TAG 8'h08
`define XARS_OFF_FSTAT 8'h0c
`define XARS_OFF_FCTRL 8'h10
`define XARS_OFF_MODE 8'h14
`define XARS_OFF_ALU 8'h18
`define XARS_OFF_XFER 8'h1c
`define XARS_OFF_SEG 8'h20
`define XARS_OFF_STK 8'h40
`define XARS_OFF_SEG_END 8'h38
`define XARS_OFF_STK_END 8'hc0
// Flag bit positions.
`define XARS_F_CF 0
`define XARS_F_PF 2
`define XARS_F_AF 4
`define XARS_F_ZF 6
`define XARS_F_SF 7
`define XARS_F_TF 8
`define XARS_F_IF 9
`define XARS_F_DF 10
`define XARS_F_OF 11
// Writable flag mask and fixed values of reserved bits (bit 1 reads one).
`define XARS_FLAGS_WMASK 32'h003f7fd5
`define XARS_FLAGS_FIXED 32'h00000002
`define XARS_FLAGS_RESET 32'h00000002
`define XARS_ARITH_MASK 32'h000008d5
// Float stack register fields.
`define XARS_FP_SIGN 79
`define XARS_FP_EXP_HI 78
`define XARS_FP_EXP_LO 64
`define XARS_TAG_RESET 16'hffff
`define XARS_FCTRL_RESET 16'h037f
`define XARS_FSTAT_RESET 16'h0000
// Packed-data aliases occupy all 64 significand bits (63:0); exponent and sign set to all ones on a write to the upper packed word.
`define XARS_MEDIA_EXP 15'h7fff
`endif

// *** common/xars_pkg.sv ***
// Types for the architectural register state block.
// Assumes xars_params.svh sits on the include path.
package xars_pkg;
   // Tag encodings of a float stack register.
   typedef enum logic [1:0] {XARS_TAG_VALID, XARS_TAG_ZERO, XARS_TAG_SPECIAL,
      XARS_TAG_EMPTY} xars_tag_e;
   // Packed-data lane view selected for a write.
   typedef enum logic [1:0] {XARS_LANE_QUAD, XARS_LANE_DWORD, XARS_LANE_WORD,
      XARS_LANE_BYTE} xars_lane_e;
   // Bus transaction phase.
   typedef enum logic [0:0] {XARS_BUS_IDLE, XARS_BUS_ACK} xars_bus_e;
   // Operand format of a float register.
   typedef enum logic [1:0] {XARS_FMT_BCD, XARS_FMT_SINGLE, XARS_FMT_DOUBLE,
      XARS_FMT_EXT} xars_fmt_e;
endpackage

// *** common/xars_stk_if.sv ***
// Interface joining the register block to its float stack memory.
// Assumes one clock and synchronous use by both ends.
`timescale 1ns/10ps
`default_nettype none
interface xars_stk_if;
   logic we; // Write strobe.
   logic [2:0] waddr; // Write index.
   logic [79:0] wdata; // Write data.
   logic [2:0] raddr; // Read index.
   logic [79:0] rdata; // Registered read data.
   // Block side.
   modport ctl (output we, waddr, wdata, raddr, input rdata);
   // Memory side.
   modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// *** hw/xars_stk_mem.sv ***
// Eight-entry memory holding the float stack registers; packed-data views alias it.
// Assumes the interface is driven from the sys_clk domain.
`timescale 1ns/10ps
`default_nettype none
module xars_stk_mem
#(
   parameter int DEPTH = 8
)
(
   input wire logic sys_clk,
   xars_stk_if.mem stk
);
   // Storage array.
   logic [79:0] mem_q [DEPTH];
   initial
   begin
      if (DEPTH != 8)
      begin
         $error("float stack depth must be eight");
      end
   end
   // Write port; the single storage serves both the float and packed views.
   always_ff @(posedge sys_clk)
   begin
      if (stk.we)
      begin
         mem_q[stk.waddr] <= stk.wdata;
      end
   end
   // Registered read port.
   always_ff @(posedge sys_clk)
   begin
      stk.rdata <= mem_q[stk.raddr];
   end
endmodule
`default_nettype wire

// *** hw/xars_regs.sv ***
// Architectural register state: flags, instruction pointer, segments, float and packed.
// Assumes a classic Wishbone master on sys_clk and synchronous active-low reset.
//
// Notes on behaviour
// - Tag word, two bits per stack register.
// - Eight 80-bit stack registers: sign, exponent, significand.
// - Packed-data registers alias the float stack storage.
// - Packed lanes: bytes, words, doublewords.
// - Vector float view is packed singles.
// - System flags at their fixed flag positions.
// - Arithmetic flags updated from results.
// - Direction, interrupt enable, trap at 10,9,8.
// - Pointer changes only by control transfers.
// - Six 16-bit segment selector registers.
// - Protected mode treats selectors as table indices.
// - Float status word and control word.
// - Float arithmetic is standard-conformant outside this block.
// - Four operand formats defined; the tag register always reports the extended one.
`include "xars_params.svh"
`timescale 1ns/10ps
`default_nettype none
module xars_regs
#(
   parameter int NSEG = 6
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic protected_mode,
   output logic [12:0] desc_index,
   output logic desc_table_local,
   output logic [1:0] desc_rpl
);
   ////////////////////////////////////////////////////////////////////////////////////////
   // Declarations.
   xars_stk_if stk ();
   logic [31:0] flags_q; // Processor flags.
   logic [31:0] iptr_q; // Next-instruction location.
   logic [15:0] tag_q; // Tag word.
   logic [15:0] fstat_q; // Float status word.
   logic [15:0] fctrl_q; // Float control word.
   logic [31:0] mode_q; // Bit 0 protected mode, bit 1 16-bit pointer, [4:2] selected segment.
   logic [15:0] seg_q [NSEG]; // Segment selectors: code, data x4, stack.
   logic req; // A bus cycle is present.
   logic ack_q; // Registered acknowledge.
   logic rd_pend_q; // Stack read waits for memory data.
   logic [2:0] stk_idx; // Stack entry addressed by the bus.
   logic [7:0] stk_off; // Byte offset from the start of the stack block.
   logic [1:0] stk_word; // Word within an entry.
   logic seg_hit; // Address lies in the segment block.
   logic stk_hit; // Address lies in the stack block.
   logic known; // Address is mapped.
   logic wr_en; // Accepted write this cycle.
   logic [31:0] alu_res; // Result pushed into the status flags.
   logic [31:0] new_flags; // Flags value after masking.
   logic [31:0] wmask; // Byte-enable mask.
   logic [79:0] merged; // Read-modify-write entry value.
   logic [79:0] stk_hold_q; // Last read or written entry, held for merges.
   logic [2:0] stk_hold_idx_q; // Index of the held entry.
   logic [31:0] rd_mux; // Register read value.
   initial
   begin
      if (NSEG != 6)
      begin
         $error("six segment registers are required");
      end
   end
   xars_stk_mem #(.DEPTH(8)) u_mem (.sys_clk(sys_clk), .stk(stk));

   ////////////////////////////////////////////////////////////////////////////////////////
   // Address decode.
   // An answer in flight blocks a second take, so ack and err each stand one cycle.
   assign req = wb_cyc_i && wb_stb_i && !ack_q && !wb_err_o;
   assign seg_hit = (wb_adr_i >= `XARS_OFF_SEG) && (wb_adr_i < `XARS_OFF_SEG_END);
   assign stk_hit = (wb_adr_i >= `XARS_OFF_STK) && (wb_adr_i < `XARS_OFF_STK_END);
   // Each stack entry spans two words plus a third for sign and exponent (word 2).
   // Eight entries of sixteen bytes each fill the stack block.
   assign stk_off = wb_adr_i - `XARS_OFF_STK;
   assign stk_idx = stk_off[6:4];
   assign stk_word = stk_off[3:2];
   assign known = (wb_adr_i[1:0] == 2'b00) && (seg_hit || (stk_hit && stk_word != 2'b11)
      || wb_adr_i < `XARS_OFF_SEG);
   assign wr_en = req && wb_we_i && known;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   ////////////////////////////////////////////////////////////////////////////////////////
   // Acknowledge: register reads answer one cycle later, stack reads two.
   // Writes and register reads answer on the cycle after a request; unmapped addresses get an error instead.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ack_q <= 1'b0;
         wb_err_o <= 1'b0;
         rd_pend_q <= 1'b0;
      end
      else
      begin
         rd_pend_q <= req && !wb_we_i && stk_hit && known && !rd_pend_q;
         // Stack reads wait one extra cycle for the memory's registered output.
         if (req && !(stk_hit && !wb_we_i && known && !rd_pend_q))
         begin
            ack_q <= known;
            wb_err_o <= !known;
         end
         else
         begin
            ack_q <= 1'b0;
            wb_err_o <= 1'b0;
         end
      end
   end
   assign wb_ack_o = ack_q;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Processor flags.
   // The arithmetic write port takes a result and derives status flags from it.
   assign alu_res = wb_dat_i;
   always_comb
   begin
      new_flags = (flags_q & ~(`XARS_FLAGS_WMASK & wmask))
         | (wb_dat_i & `XARS_FLAGS_WMASK & wmask);
      new_flags = (new_flags & ~`XARS_FLAGS_WMASK) | (new_flags & `XARS_FLAGS_WMASK);
      new_flags = (new_flags & `XARS_FLAGS_WMASK) | `XARS_FLAGS_FIXED;
   end
   // Flags update on direct writes and on results posted to the arithmetic port.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         flags_q <= `XARS_FLAGS_RESET;
      end
      else if (wr_en && wb_adr_i == `XARS_OFF_FLAGS)
      begin
         flags_q <= new_flags;
      end
      else if (wr_en && wb_adr_i == `XARS_OFF_ALU)
      begin
         // Zero, sign and parity follow the low byte and the whole result.
         flags_q[`XARS_F_ZF] <= (alu_res == 32'h00000000);
         flags_q[`XARS_F_SF] <= alu_res[31];
         flags_q[`XARS_F_PF] <= ~^alu_res[7:0];
         // Carry, auxiliary carry and overflow arrive as sideband in the select lines.
         flags_q[`XARS_F_CF] <= wb_sel_i[0];
         flags_q[`XARS_F_AF] <= wb_sel_i[1];
         flags_q[`XARS_F_OF] <= wb_sel_i[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Instruction pointer: a direct write is ignored; only the transfer port moves it.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         iptr_q <= 32'h00000000;
      end
      else if (wr_en && wb_adr_i == `XARS_OFF_XFER)
      begin
         // In 16-bit mode the upper half stays clear.
         iptr_q <= mode_q[1] ? {16'h0000, wb_dat_i[15:0]} : wb_dat_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Mode and segment selectors.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         mode_q <= 32'h00000000;
      end
      else if (wr_en && wb_adr_i == `XARS_OFF_MODE)
      begin
         mode_q <= {27'h0, wb_dat_i[4:0] & 5'h1f};
      end
   end
   // One always block per selector via a generate loop.
   for (genvar g = 0; g < NSEG; g++)
   begin : g_seg
      always_ff @(posedge sys_clk)
      begin
         if (!rst_n)
         begin
            seg_q[g] <= 16'h0000;
         end
         else if (wr_en && seg_hit && wb_adr_i[4:2] == 3'(g))
         begin
            seg_q[g] <= (seg_q[g] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
         end
      end
   end
   // Selected selector decomposed into table index, table select and privilege.
   always_comb
   begin
      protected_mode = mode_q[0];
      desc_index = mode_q[0] ? seg_q[mode_q[4:2] % 3'd6][15:3] : 13'h0000;
      desc_table_local = mode_q[0] && seg_q[mode_q[4:2] % 3'd6][2];
      desc_rpl = mode_q[0] ? seg_q[mode_q[4:2] % 3'd6][1:0] : 2'b00;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Float tag, status and control words.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         tag_q <= `XARS_TAG_RESET;
         fstat_q <= `XARS_FSTAT_RESET;
         fctrl_q <= `XARS_FCTRL_RESET;
      end
      else if (wr_en && wb_adr_i == `XARS_OFF_TAG)
      begin
         tag_q <= (tag_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
      else if (wr_en && wb_adr_i == `XARS_OFF_FSTAT)
      begin
         fstat_q <= (fstat_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
      else if (wr_en && wb_adr_i == `XARS_OFF_FCTRL)
      begin
         fctrl_q <= (fctrl_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
      else if (wr_en && stk_hit)
      begin
         // A packed-data write marks its entry valid, as media instructions do.
         tag_q[{stk_idx, 1'b0} +: 2] <= 2'(xars_pkg::XARS_TAG_VALID);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Float stack access: word 0 and 1 are the packed-data view, word 2 sign and exponent.
   // Track the last entry read or written so a partial write merges with current contents.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         stk_hold_q <= 80'h0;
         stk_hold_idx_q <= 3'h0;
      end
      else if (rd_pend_q)
      begin
         stk_hold_q <= stk.rdata;
         stk_hold_idx_q <= stk_idx;
      end
      else if (stk.we)
      begin
         stk_hold_q <= stk.wdata;
         stk_hold_idx_q <= stk.waddr;
      end
   end
   // Software reads an entry before a partial write; the merge uses the held copy.
   always_comb
   begin
      merged = (stk_hold_idx_q == stk_idx) ? stk_hold_q : 80'h0;
      case (stk_word)
         2'b00: merged[31:0] = (merged[31:0] & ~wmask) | (wb_dat_i & wmask);
         2'b01:
         begin
            merged[63:32] = (merged[63:32] & ~wmask) | (wb_dat_i & wmask);
            // A write to the upper packed word sets the exponent field all ones.
            merged[`XARS_FP_EXP_HI:`XARS_FP_EXP_LO] = `XARS_MEDIA_EXP;
            merged[`XARS_FP_SIGN] = 1'b1;
         end
         2'b10:
         begin
            merged[`XARS_FP_SIGN] = wb_dat_i[15];
            merged[`XARS_FP_EXP_HI:`XARS_FP_EXP_LO] = wb_dat_i[14:0];
         end
         default: merged = merged;
      endcase
   end
   assign stk.we = wr_en && stk_hit;
   assign stk.waddr = stk_idx;
   assign stk.wdata = merged;
   assign stk.raddr = stk_idx;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Read mux; bits 17:16 of the tag register read as the extended operand format.
   always_comb
   begin
      rd_mux = 32'h00000000;
      if (stk_hit)
      begin
         case (stk_word)
            2'b00: rd_mux = stk.rdata[31:0];
            2'b01: rd_mux = stk.rdata[63:32];
            2'b10: rd_mux = {16'h0000, stk.rdata[`XARS_FP_SIGN:`XARS_FP_EXP_LO]};
            default: rd_mux = 32'h00000000;
         endcase
      end
      else if (seg_hit)
      begin
         rd_mux = (wb_adr_i[4:2] < 3'(NSEG)) ? {16'h0000, seg_q[wb_adr_i[4:2]]} : 32'h0;
      end
      else
      begin
         case (wb_adr_i)
            `XARS_OFF_FLAGS: rd_mux = flags_q;
            `XARS_OFF_IPTR: rd_mux = iptr_q;
            `XARS_OFF_TAG: rd_mux = {14'h0000, 2'(xars_pkg::XARS_FMT_EXT), tag_q};
            `XARS_OFF_FSTAT: rd_mux = {16'h0000, fstat_q};
            `XARS_OFF_FCTRL: rd_mux = {16'h0000, fctrl_q};
            `XARS_OFF_MODE: rd_mux = mode_q;
            default: rd_mux = 32'h00000000;
         endcase
      end
   end
   // Read data register, loaded when the answer is produced.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         wb_dat_o <= 32'h00000000;
      end
      else if (req && !wb_we_i && (rd_pend_q || !stk_hit))
      begin
         wb_dat_o <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Assertions.
   sequence s_flag_write;
      wr_en && wb_adr_i == `XARS_OFF_FLAGS;
   endsequence
   property p_reserved_fixed;
      @(posedge sys_clk) disable iff (!rst_n)
      (flags_q & ~`XARS_FLAGS_WMASK) == `XARS_FLAGS_FIXED;
   endproperty
   a_reserved_fixed: assert property (p_reserved_fixed) else $error("reserved bits moved");
   property p_df_written;
      @(posedge sys_clk) disable iff (!rst_n)
      s_flag_write and wb_sel_i[1] |=> flags_q[`XARS_F_DF] == $past(wb_dat_i[10]);
   endproperty
   a_df_written: assert property (p_df_written) else $error("direction flag not stored");
   property p_id_written;
      @(posedge sys_clk) disable iff (!rst_n)
      s_flag_write and wb_sel_i[2] |=> flags_q[21] == $past(wb_dat_i[21]);
   endproperty
   a_id_written: assert property (p_id_written) else $error("toggle flag not stored");
   property p_zero_flag;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_en && wb_adr_i == `XARS_OFF_ALU |=> flags_q[`XARS_F_ZF] == ($past(wb_dat_i) == 0);
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");
   property p_iptr_stable;
      @(posedge sys_clk) disable iff (!rst_n)
      !(wr_en && wb_adr_i == `XARS_OFF_XFER) |=> $stable(iptr_q);
   endproperty
   a_iptr_stable: assert property (p_iptr_stable) else $error("pointer moved");
   property p_tag_valid;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_en && stk_hit |=> tag_q[{$past(stk_idx), 1'b0} +: 2] == 2'b00;
   endproperty
   a_tag_valid: assert property (p_tag_valid) else $error("tag not valid");
   property p_stk_ack;
      @(posedge sys_clk) disable iff (!rst_n)
      req && !wb_we_i && stk_hit && known && !rd_pend_q |=> !wb_ack_o ##1 wb_ack_o;
   endproperty
   a_stk_ack: assert property (p_stk_ack) else $error("stack read answer late");
   property p_seg_write;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_en && seg_hit && wb_adr_i[4:2] == 3'd0 && wb_sel_i == 4'hf
      |=> seg_q[0] == $past(wb_dat_i[15:0]);
   endproperty
   a_seg_write: assert property (p_seg_write) else $error("selector not stored");
   property p_real_index;
      @(posedge sys_clk) disable iff (!rst_n)
      !mode_q[0] |-> desc_index == 13'h0000 && !protected_mode;
   endproperty
   a_real_index: assert property (p_real_index) else $error("index in real mode");
endmodule
`default_nettype wire

// *** tb/xars_regs_tb_top.sv ***
// Self-checking bench for the architectural register state block, driven over classic Wishbone.
// Assumes the common headers, the package and the design sources are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module xars_regs_tb_top;
   ////////////////////////////////////////////////////////////////////////////////////////////
   logic sys_clk; // Core clock, 50 MHz.
   logic rst_n; // Synchronous reset, active low.
   logic cyc; // Bus cycle.
   logic stb; // Bus strobe.
   logic we; // Bus direction.
   logic [7:0] adr; // Byte address.
   logic [3:0] sel; // Byte enables.
   logic [31:0] dat_w; // Write data.
   logic [31:0] dat_r; // Read data.
   logic ack; // Acknowledge pulse.
   logic err_p; // Error pulse.
   logic pmode; // Protected mode level.
   logic [12:0] dindex; // Descriptor index.
   logic tbl_local; // Local table select.
   logic [1:0] drpl; // Requested privilege.
   int errors; // Mismatches seen.
   int check_count; // Comparisons made.
   logic [31:0] flags_m; // Model of the flags register.
   logic [15:0] tag_m; // Model of the tag word.
   logic [15:0] seg_m [6]; // Model of the selectors.
   logic [31:0] rdv; // Data of the last answer.
   logic last_err; // Error flag of the last answer.
   logic [31:0] lo, hi, d; // Scratch words.
   logic [3:0] s; // Scratch byte enables.
   logic [15:0] x; // Scratch half word.
   logic [7:0] bad [5] = '{8'h01, 8'h3c, 8'h4c, 8'h86, 8'hfc}; // Refused addresses.

   // Free-running clock.
   always #10 sys_clk = ~sys_clk;

   // Device under test.
   xars_regs #(.NSEG(6)) xars_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
      .wb_dat_o(dat_r), .wb_ack_o(ack), .wb_err_o(err_p), .protected_mode(pmode),
      .desc_index(dindex), .desc_table_local(tbl_local), .desc_rpl(drpl));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Compares one value with its expectation and reports a difference.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // One classic cycle; entered just after a rising edge, holds until ack or err is sampled.
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] sl,
      input logic [31:0] dv);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= sl;
      dat_w <= dv;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (ack !== 1'b1 && err_p !== 1'b1 && n < 50);
      chk({31'h0, n < 50}, 32'h1);
      rdv = dat_r;
      last_err = err_p;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      // The strobe stays low for one cycle so the slave can drop its answer.
      @(posedge sys_clk);
   endtask

   // Holds reset for three cycles and returns the models to their reset state.
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      flags_m = 32'h00000002;
      tag_m = 16'hffff;
      seg_m = '{default: 16'h0};
   endtask

   // Reads the plain registers and the selectors and compares them with reset values.
   task automatic check_resets();
      logic [31:0] exp [6];
      exp = '{32'h2, 32'h0, 32'h3ffff, 32'h0, 32'h37f, 32'h0};
      for (int i = 0; i < 6; i++)
      begin
         bus(1'b0, 8'(4 * i), 4'hf, 32'h0);
         chk(rdv, exp[i]);
         bus(1'b0, 8'h20 + 8'(4 * i), 4'hf, 32'h0);
         chk(rdv, 32'h0);
      end
      chk({31'h0, pmode}, 32'h0);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Watchdog: the tests need several hundred cycles, so this span means a hang.
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      give_verdict();
   end

   // Main sequence.
   initial
   begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat_w = 32'h0;
      errors = 0;
      check_count = 0;
      void'($urandom(90045));
      @(posedge sys_clk);
      do_reset();
      check_resets();
      // Flags: only named bits take the written value, reserved bits stay fixed.
      for (int i = 0; i < 4; i++)
      begin
         d = (i == 0) ? 32'hffffffff : (($urandom & 32'h003f7fd5) | 32'h00000002);
         bus(1'b1, 8'h00, 4'hf, d);
         flags_m = (d & 32'h003f7fd5) | 32'h00000002;
         bus(1'b0, 8'h00, 4'hf, 32'h0);
         chk(rdv, flags_m);
      end
      // Arithmetic results update the status flags and leave the others alone.
      for (int i = 0; i < 6; i++)
      begin
         d = (i == 0) ? 32'h0 : $urandom;
         s = 4'($urandom);
         bus(1'b1, 8'h18, s, d);
         flags_m = flags_m & ~32'h000008d5;
         flags_m[0] = s[0];
         flags_m[2] = ~^d[7:0];
         flags_m[4] = s[1];
         flags_m[6] = (d == 32'h0);
         flags_m[7] = d[31];
         flags_m[11] = s[2];
         bus(1'b0, 8'h00, 4'hf, 32'h0);
         chk(rdv, flags_m);
      end
      // The pointer ignores direct writes and follows control transfers.
      d = $urandom;
      bus(1'b1, 8'h04, 4'hf, d);
      bus(1'b0, 8'h04, 4'hf, 32'h0);
      chk(rdv, 32'h0);
      bus(1'b1, 8'h1c, 4'hf, d);
      bus(1'b1, 8'h04, 4'hf, ~d);
      bus(1'b0, 8'h04, 4'hf, 32'h0);
      chk(rdv, d);
      // With the 16-bit pointer selected, a transfer keeps the upper half clear.
      bus(1'b1, 8'h14, 4'hf, 32'h00000002);
      bus(1'b1, 8'h1c, 4'hf, ~d);
      bus(1'b0, 8'h04, 4'hf, 32'h0);
      chk(rdv, {16'h0, ~d[15:0]});
      bus(1'b1, 8'h14, 4'hf, 32'h00000000);
      // Float status and control words.
      for (int i = 3; i < 5; i++)
      begin
         x = 16'($urandom);
         bus(1'b1, 8'(4 * i), 4'hf, {16'h0, x});
         bus(1'b0, 8'(4 * i), 4'hf, 32'h0);
         chk(rdv, {16'h0, x});
      end
      // Selectors, then each one picked in protected mode, picks past five wrap.
      for (int i = 0; i < 6; i++)
      begin
         seg_m[i] = 16'($urandom);
         bus(1'b1, 8'h20 + 8'(4 * i), 4'hf, {16'h0, seg_m[i]});
      end
      for (int i = 0; i < 8; i++)
      begin
         if (i < 6)
         begin
            bus(1'b0, 8'h20 + 8'(4 * i), 4'hf, 32'h0);
            chk(rdv, {16'h0, seg_m[i]});
         end
         bus(1'b1, 8'h14, 4'hf, {27'h0, 3'(i), 2'b01});
         chk({15'h0, pmode, dindex, tbl_local, drpl}, {15'h0, 1'b1, seg_m[i % 6]});
      end
      bus(1'b1, 8'h14, 4'hf, 32'h00000014);
      chk({15'h0, pmode, dindex, tbl_local, drpl}, 32'h0);
      // Stack entries through the packed view, lane merges and the sign and exponent word.
      for (int n = 0; n < 8; n++)
      begin
         lo = $urandom;
         hi = $urandom;
         d = $urandom;
         s = 4'($urandom);
         x = 16'($urandom);
         bus(1'b1, 8'h40 + 8'(16 * n), 4'hf, lo);
         bus(1'b1, 8'h44 + 8'(16 * n), 4'hf, hi);
         tag_m[2 * n +: 2] = 2'b00;
         bus(1'b0, 8'h48 + 8'(16 * n), 4'hf, 32'h0);
         chk(rdv, 32'h0000ffff);
         bus(1'b1, 8'h40 + 8'(16 * n), s, d);
         for (int b = 0; b < 4; b++)
            if (s[b])
               lo[8 * b +: 8] = d[8 * b +: 8];
         bus(1'b0, 8'h40 + 8'(16 * n), 4'hf, 32'h0);
         chk(rdv, lo);
         bus(1'b0, 8'h44 + 8'(16 * n), 4'hf, 32'h0);
         chk(rdv, hi);
         bus(1'b1, 8'h48 + 8'(16 * n), 4'hf, {16'h0, x});
         bus(1'b0, 8'h48 + 8'(16 * n), 4'hf, 32'h0);
         chk(rdv, {16'h0, x});
      end
      bus(1'b0, 8'h08, 4'hf, 32'h0);
      chk(rdv, {14'h0, 2'h3, tag_m});
      // Refused places answer with an error and change nothing.
      foreach (bad[i])
      begin
         bus(1'b1, bad[i], 4'hf, 32'hffffffff);
         chk({31'h0, last_err}, 32'h1);
      end
      bus(1'b0, 8'h00, 4'hf, 32'h0);
      chk(rdv, flags_m);
      // A second reset in mid-run restores every reset value.
      do_reset();
      check_resets();
      give_verdict();
   end
endmodule
`default_nettype wire
